/* design/eeprom_ctl.v */
/*
 * eeprom program/erase controller: control register, array config copy,
 * write capture latch, high voltage interlock and stop mode handling,
 * reached over an avalon-mm slave with waitrequest.
 * assumes an array macro outside that reads combinationally from
 * array_rd_addr and performs the operation while hv_on is high.
 */
`timescale 1ns/1ps
`include "eeprom_ctl_defs.vh"

module eeprom_ctl (
    input wire sys_clk,
    input wire rst,
    input wire [13:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire stop_mode,
    input wire [7:0] nv_config_cell,
    input wire [7:0] array_rdata,
    output wire [9:0] array_rd_addr,
    output reg pump_clock_select,
    output reg array_power_down,
    output reg hv_on,
    output reg [1:0] op_mode,
    output reg [9:0] op_addr,
    output reg [7:0] op_data,
    output reg op_nv,
    output reg mirror_en,
    output reg [9:0] mirror_addr,
    output reg redundant_mode
);

    // ****************************************************************
    // register state
    // ****************************************************************

    // software-visible registers, bus ack and the write capture latch
    reg [7:0] control;
    reg [7:0] config_copy;
    reg reload_pending;
    reg ack;
    reg cap_valid;
    reg [9:0] cap_addr;
    reg [7:0] cap_data;
    reg cap_nv;

    // control and config copy fields
    wire hv_enable = control[`CTL_HV_ENABLE];
    wire bus_latch_ctl = control[`CTL_BUS_LATCH];
    wire [1:0] erase_mode = {control[`CTL_ERASE_HI], control[`CTL_ERASE_LO]};
    wire [2:0] block_protect_bit = config_copy[`CFG_BP_HI:`CFG_BP_LO];
    wire redundancy_select = config_copy[`CFG_REDUNDANT];

    // ****************************************************************
    // bus decode
    // ****************************************************************

    // full-word compare of the bus address with one register offset
    function reg_hit;
        input [13:0] addr;
        input [13:0] ofs;
        begin
            reg_hit = (addr == ofs);
        end
    endfunction

    wire req = avs_read | avs_write;
    wire lane0 = avs_byteenable[0];
    // register selects and the array window
    wire sel_ctl = reg_hit(avs_address, `OFS_CONTROL);
    wire sel_copy = reg_hit(avs_address, `OFS_CONFIG_COPY);
    wire sel_nv = reg_hit(avs_address, `OFS_NV_CONFIG);
    wire sel_win = (avs_address[`WIN_SEL_HI:`WIN_SEL_LO] == `ARRAY_WINDOW_SEL);
    wire [9:0] win_idx = avs_address[`WIN_IDX_HI:`WIN_IDX_LO];
    wire win_in_range = sel_win & (win_idx < `ARRAY_BYTES);
    wire [7:0] wbyte = avs_writedata[7:0];

    // every access waits exactly one cycle, then completes
    // ack drops after each completion, so back-to-back requests wait again
    assign avs_waitrequest = req & ~ack;
    wire take = req & ack;
    wire wr_take = take & avs_write & lane0;
    wire rd_take = take & avs_read;

    // array macro read address follows the bus window index
    assign array_rd_addr = win_idx;

    // ****************************************************************
    // protection decode of a candidate write and of the captured write
    // ****************************************************************

    wire [9:0] chk_addr = sel_nv ? cap_addr : win_idx;
    wire chk_ok;

    // validity of the address a write is about to be captured at
    protect_check u_new_chk (
        .addr(chk_addr),
        .is_nv(sel_nv),
        .mode(erase_mode),
        .protect(block_protect_bit),
        .redundant(redundancy_select),
        .addr_ok(chk_ok),
        .permit(),
        .mirror()
    );

    wire cap_permit;
    wire cap_mirror;

    // the same decode judged against what the latch already holds
    // permission and mirroring of the captured write
    protect_check u_cap_chk (
        .addr(cap_addr),
        .is_nv(cap_nv),
        .mode(erase_mode),
        .protect(block_protect_bit),
        .redundant(redundancy_select),
        .addr_ok(),
        .permit(cap_permit),
        .mirror(cap_mirror)
    );

    // a write landing in the array or on the config byte
    wire array_wr = wr_take & ((win_in_range & chk_ok) | sel_nv);

    // ****************************************************************
    // next control value
    // ****************************************************************

    reg [7:0] next_control;

    // hv enable rules come last, so one write cannot bypass them
    // interlocks applied to a control register write
    always @* begin
        next_control = control;
        if (wr_take && sel_ctl) begin
            next_control = wbyte & `CTL_WRITABLE; // bits 6 and 2 read 0
            if (hv_enable) begin
                next_control[`CTL_BUS_LATCH] = 1'b1;
                next_control[`CTL_ERASE_HI] = control[`CTL_ERASE_HI];
                next_control[`CTL_ERASE_LO] = control[`CTL_ERASE_LO];
            end
            if (wbyte[`CTL_HV_ENABLE] && !hv_enable) begin
                // only with latch on and a captured array or config byte write
                // a write that drops the latch at once cannot start the pump
                next_control[`CTL_HV_ENABLE] = bus_latch_ctl & wbyte[`CTL_BUS_LATCH] & cap_valid;
            end
        end
    end

    // ****************************************************************
    // control register and bus handshake
    // ****************************************************************

    // control register, reset clears every field
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            control <= `CTL_RESET;
            ack <= 1'b0;
        end else begin
            control <= next_control;
            ack <= req & ~ack;
        end
    end

    // ****************************************************************
    // write capture latch
    // ****************************************************************

    // the capture is frozen while high voltage is on, so the target holds
    // with latch on, the newest valid write overrides the previous one
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cap_valid <= 1'b0;
            cap_addr <= 10'h000;
            cap_data <= 8'h00;
            cap_nv <= 1'b0;
        end else if (!bus_latch_ctl) begin
            cap_valid <= 1'b0; // normal read operation restored
        end else if (array_wr && !hv_enable) begin
            cap_valid <= 1'b1;
            cap_addr <= sel_nv ? 10'h000 : win_idx;
            cap_data <= wbyte;
            cap_nv <= sel_nv;
        end
    end

    // ****************************************************************
    // configuration copy
    // ****************************************************************

    // the cell cannot be sampled in reset, so the load waits one edge
    // reload after reset release and on every nv byte read
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            config_copy <= `CFG_RESET;
            reload_pending <= 1'b1;
        end else begin
            reload_pending <= 1'b0;
            if (reload_pending || (rd_take && sel_nv)) begin
                config_copy <= nv_config_cell & `CFG_USED_MASK;
            end
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************

    reg [7:0] next_rbyte;

    // read mux; captured data shadows array reads while latched
    always @* begin
        next_rbyte = 8'h00;
        if (sel_ctl) begin
            next_rbyte = control;
        end else if (sel_copy) begin
            next_rbyte = config_copy;
        end else if (sel_nv) begin
            next_rbyte = nv_config_cell;
        end else if (win_in_range) begin
            if (bus_latch_ctl && cap_valid) begin
                next_rbyte = cap_data;
            end else begin
                next_rbyte = array_rdata; // undefined while powered down
            end
        end
    end

    // data registered at the waitrequest high cycle, held to completion
    // registering in the wait cycle keeps the answer steady at the take edge
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !ack) begin
            avs_readdata <= {24'h000000, next_rbyte};
        end
    end

    // ****************************************************************
    // array drive outputs
    // ****************************************************************

    // high voltage follows the enable bit except during stop; stop does
    // not touch the bit, so leaving stop brings the voltage back, and
    // wait mode has no path here at all
    // a protected or missing target never sees voltage, whatever the mode
    wire next_hv_on = hv_enable & bus_latch_ctl & cap_valid & cap_permit & ~stop_mode;

    // op address, data and nv follow the capture one edge later, like every output here
    // registered drive to the array macro
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pump_clock_select <= 1'b0;
            array_power_down <= 1'b0;
            hv_on <= 1'b0;
            op_mode <= `MODE_BYTE_PROG;
            op_addr <= 10'h000;
            op_data <= 8'h00;
            op_nv <= 1'b0;
            mirror_en <= 1'b0;
            mirror_addr <= 10'h000;
            redundant_mode <= 1'b0;
        end else begin
            pump_clock_select <= control[`CTL_PUMP_CLK];
            array_power_down <= control[`CTL_POWER_DOWN];
            hv_on <= next_hv_on;
            op_mode <= erase_mode;
            op_addr <= cap_addr;
            op_data <= cap_data;
            op_nv <= cap_nv;
            mirror_en <= cap_mirror;
            mirror_addr <= cap_addr + `MIRROR_OFFSET;
            redundant_mode <= redundancy_select;
        end
    end

endmodule // eeprom_ctl

/* design/eeprom_ctl_defs.vh */
/*
 * constants for the eeprom program/erase control block: register
 * offsets, bit positions, reset values, array geometry and mode codes.
 * assumes inclusion by bare name from the design files.
 */
`ifndef EEPROM_CTL_DEFS_VH
`define EEPROM_CTL_DEFS_VH

// ****************************************************************
// register map (byte addresses on the avalon slave)
// ****************************************************************
`define OFS_CONTROL 14'h0000
`define OFS_CONFIG_COPY 14'h0004
`define OFS_NV_CONFIG 14'h0008
`define ARRAY_WINDOW_SEL 2'h1
`define BUS_ADDR_W 14
`define BUS_DATA_W 32
`define WIN_SEL_HI 13
`define WIN_SEL_LO 12
`define WIN_IDX_HI 11
`define WIN_IDX_LO 2

// ****************************************************************
// control register bit positions and reset value
// ****************************************************************
`define CTL_HV_ENABLE 0
`define CTL_BUS_LATCH 1
`define CTL_ERASE_LO 3
`define CTL_ERASE_HI 4
`define CTL_POWER_DOWN 5
`define CTL_PUMP_CLK 7
`define CTL_RESET 8'h00
`define CTL_WRITABLE 8'hbb

// ****************************************************************
// configuration byte bit positions
// ****************************************************************
`define CFG_BP_LO 0
`define CFG_BP_HI 2
`define CFG_REDUNDANT 4
`define CFG_USED_MASK 8'h17
`define CFG_RESET 8'h00

// ****************************************************************
// array geometry (byte index within the array)
// ****************************************************************
`define ARRAY_IDX_W 10
`define ARRAY_BYTES 10'h280
`define BLOCK1_START 10'h100
`define BLOCK2_START 10'h200
`define MIRROR_SPAN 10'h080
`define MIRROR_OFFSET 10'h200

// ****************************************************************
// operation codes of the two-bit erase field
// ****************************************************************
`define MODE_BYTE_PROG 2'h0
`define MODE_BYTE_ERASE 2'h1
`define MODE_BLOCK_ERASE 2'h2
`define MODE_BULK_ERASE 2'h3

`endif

/* design/protect_check.v */
/*
 * protection and redundancy decode for one candidate or captured array write.
 * assumes a byte index inside the array and the active config bits.
 */
`timescale 1ns/1ps
`include "eeprom_ctl_defs.vh"

module protect_check (
    input wire [9:0] addr,
    input wire is_nv,
    input wire [1:0] mode,
    input wire [2:0] protect,
    input wire redundant,
    output reg addr_ok,
    output reg permit,
    output reg mirror
);

    // ****************************************************************
    // block decode
    // ****************************************************************

    // which of the three protection blocks holds an index
    function [1:0] block_of;
        input [9:0] idx;
        begin
            if (idx < `BLOCK1_START) begin
                block_of = 2'h0;
            end else if (idx < `BLOCK2_START) begin
                block_of = 2'h1;
            end else begin
                block_of = 2'h2;
            end
        end
    endfunction

    // in redundant mode the third block bit carries no meaning
    wire [2:0] eff_protect = redundant ? {1'b0, protect[1:0]} : protect;
    wire [1:0] blk = block_of(addr);

    // ****************************************************************
    // decision
    // ****************************************************************

    // address validity, permission and mirroring
    always @* begin
        addr_ok = is_nv | (addr < `ARRAY_BYTES);
        if (!is_nv && redundant && (blk == 2'h2)) begin
            addr_ok = 1'b0; // upper mirror bytes not addressable
        end
        if (is_nv) begin
            permit = 1'b1; // config byte sits outside the blocks
        end else if (mode == `MODE_BULK_ERASE) begin
            permit = ~|eff_protect; // any protected block stops bulk
        end else begin
            permit = ~eff_protect[blk];
        end
        mirror = redundant & ~is_nv & (addr < `MIRROR_SPAN);
    end

endmodule // protect_check

/* verification/eeprom_ctl_sva.sv */
/* checker for eeprom_ctl: bus latency, derived outputs, stop, mirror.
   assumes binding to eeprom_ctl, seeing its ports only. */
`timescale 1ns/1ps
module eeprom_ctl_sva (
    input wire sys_clk,
    input wire rst,
    input wire [13:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire stop_mode,
    input wire [7:0] nv_config_cell,
    input wire pump_clock_select,
    input wire array_power_down,
    input wire hv_on,
    input wire [1:0] op_mode,
    input wire [9:0] op_addr,
    input wire mirror_en,
    input wire [9:0] mirror_addr,
    input wire redundant_mode
);
default clocking @(posedge sys_clk); endclocking
default disable iff (rst);
// ****************
// completed bus steps
// ****************
sequence ctl_wr_done;
    avs_write && !avs_waitrequest && avs_address == 14'h0000 && avs_byteenable[0];
endsequence
sequence nv_rd_done;
    avs_read && !avs_waitrequest && avs_address == 14'h0008;
endsequence
// ****************
// properties
// ****************
a_one_wait_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest) else $error("bus answer late");
a_pump_clk_follow: assert property (ctl_wr_done |-> ##2
    pump_clock_select == $past(avs_writedata[7], 2)) else $error("pump clock wrong");
a_power_down_follow: assert property (ctl_wr_done |-> ##2
    array_power_down == $past(avs_writedata[5], 2)) else $error("power down wrong");
a_stop_drops_hv: assert property (stop_mode |=> !hv_on)
    else $error("high voltage in stop");
a_mode_frozen: assert property (hv_on && $past(hv_on) |-> $stable(op_mode))
    else $error("mode changed under voltage");
a_mirror_addr: assert property (mirror_en |->
    op_addr < 10'h080 && mirror_addr == op_addr + 10'h200) else $error("mirror wrong");
a_upper_zero: assert property (avs_read && !avs_waitrequest |->
    avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
a_nv_read_raw: assert property (nv_rd_done |->
    avs_readdata[7:0] == $past(nv_config_cell)) else $error("nv read wrong");
a_copy_reload: assert property (nv_rd_done |-> ##2
    redundant_mode == $past(nv_config_cell[4], 2)) else $error("copy not reloaded");
endmodule // eeprom_ctl_sva

bind eeprom_ctl eeprom_ctl_sva u_sva (.sys_clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .stop_mode,
    .nv_config_cell, .pump_clock_select, .array_power_down, .hv_on, .op_mode, .op_addr,
    .mirror_en, .mirror_addr, .redundant_mode);

/* verification/eeprom_ctl_tb.sv */
/* testbench for eeprom_ctl: register, latch, interlock, stop, protect.
   assumes an avalon slave with waitrequest; tasks wait for its answer. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
    $display("wrong value %s exp %h got %h", n, e, g); fails++; end end
module eeprom_ctl_tb;
reg sys_clk = 0, rst = 1, avs_read = 0, avs_write = 0, stop_mode = 0;
reg [13:0] avs_address = 14'h0000;
reg [31:0] avs_writedata = 32'h0, rv;
reg [3:0] avs_byteenable = 4'h1;
reg [7:0] nv_config_cell = 8'h15, array_rdata = 8'h3c;
wire [31:0] avs_readdata;
wire avs_waitrequest, pump_clock_select, array_power_down, hv_on, op_nv, mirror_en;
wire redundant_mode;
wire [9:0] array_rd_addr, op_addr, mirror_addr;
wire [1:0] op_mode;
wire [7:0] op_data;
integer fails = 0, checked = 0, cycles = 0, m;
// clock
always #10 sys_clk = ~sys_clk;
eeprom_ctl u_dut (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .stop_mode, .nv_config_cell,
    .array_rdata, .array_rd_addr, .pump_clock_select, .array_power_down, .hv_on, .op_mode,
    .op_addr, .op_data, .op_nv, .mirror_en, .mirror_addr, .redundant_mode);
// ****************
// bus tasks
// ****************
function [13:0] wa(input [9:0] i);
    wa = 14'h1000 + {2'b00, i, 2'b00};
endfunction
task cyc(input integer n);
    repeat (n) @(posedge sys_clk);
endtask
task wr(input [13:0] a, input [7:0] d);
    begin
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= 1'b1;
        @(posedge sys_clk iff avs_waitrequest === 1'b0);
        avs_write <= 1'b0;
    end
endtask
task rd(input [13:0] a, input [7:0] e, input [8*8:1] n);
    begin
        @(posedge sys_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge sys_clk iff avs_waitrequest === 1'b0);
        rv = avs_readdata;
        avs_read <= 1'b0;
        `CHK(n, {24'h0, e}, rv)
    end
endtask
task end_of_test;
    begin
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    end
endtask
// hang guard
always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
        fails = fails + 1;
        end_of_test;
    end
end
// ****************
// tests
// ****************
initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    cyc(2);
    rd(14'h0000, 8'h00, "ctl");
    rd(14'h0004, 8'h15, "copy");
    `CHK("red", 1'b1, redundant_mode)
    rd(14'h0010, 8'h00, "unmap");
    $display("test reset done");
    wr(14'h0000, 8'ha0);
    cyc(2);
    `CHK("pump", 1'b1, pump_clock_select)
    `CHK("pdn", 1'b1, array_power_down)
    wr(14'h0000, 8'hff);
    rd(14'h0000, 8'hba, "ctl");
    avs_byteenable <= 4'h0;
    wr(14'h0000, 8'h00);
    rd(14'h0000, 8'hba, "ctl");
    avs_byteenable <= 4'h1;
    wr(14'h0000, 8'h00);
    cyc(2);
    `CHK("pump", 1'b0, pump_clock_select)
    `CHK("pdn", 1'b0, array_power_down)
    cyc(4); // recovery after power-up before any array access
    rd(wa(10'h005), 8'h3c, "arr");
    `CHK("rda", 10'h005, array_rd_addr)
    $display("test control done");
    nv_config_cell <= 8'h00;
    rd(14'h0008, 8'h00, "nv");
    rd(14'h0004, 8'h00, "copy");
    wr(14'h0000, 8'h02);
    wr(wa(10'h105), 8'h5a);
    cyc(2);
    `CHK("adr", 10'h105, op_addr)
    `CHK("dat", 8'h5a, op_data)
    rd(wa(10'h020), 8'h5a, "latched");
    wr(14'h0000, 8'h03);
    cyc(2);
    `CHK("hv", 1'b1, hv_on)
    wr(14'h0000, 8'h1b);
    rd(14'h0000, 8'h03, "ctl");
    `CHK("mode", 2'h0, op_mode)
    stop_mode <= 1'b1;
    cyc(2);
    `CHK("hv", 1'b0, hv_on)
    rd(14'h0000, 8'h03, "ctl");
    stop_mode <= 1'b0;
    cyc(2);
    `CHK("hv", 1'b1, hv_on)
    wr(14'h0000, 8'h00);
    rd(14'h0000, 8'h02, "ctl");
    `CHK("hv", 1'b0, hv_on)
    wr(14'h0000, 8'h00);
    stop_mode <= 1'b1; // stop only with hv enable clear
    cyc(2);
    `CHK("hv", 1'b0, hv_on)
    stop_mode <= 1'b0;
    cyc(4); // no array access during stop recovery
    $display("test program done");
    nv_config_cell <= 8'h01;
    rd(14'h0008, 8'h01, "nv");
    for (m = 0; m < 4; m++) begin
        wr(14'h0000, {3'b000, m[1:0], 3'b010});
        wr(wa(10'h150), 8'h00);
        wr(14'h0000, {3'b000, m[1:0], 3'b011});
        cyc(2);
        `CHK("mode", m[1:0], op_mode)
        `CHK("hv", m != 3, hv_on)
        wr(14'h0000, 8'h00);
        wr(14'h0000, 8'h00);
    end
    wr(14'h0000, 8'h02);
    wr(wa(10'h010), 8'h00);
    wr(14'h0000, 8'h03);
    cyc(2);
    `CHK("hv", 1'b0, hv_on)
    wr(14'h0000, 8'h00);
    wr(14'h0000, 8'h00);
    $display("test protect done");
    nv_config_cell <= 8'h10;
    rd(14'h0008, 8'h10, "nv");
    wr(14'h0000, 8'h02);
    wr(wa(10'h040), 8'ha5);
    cyc(2);
    `CHK("red", 1'b1, redundant_mode)
    `CHK("mir", 1'b1, mirror_en)
    `CHK("madr", 10'h240, mirror_addr)
    wr(wa(10'h240), 8'h11);
    cyc(2);
    `CHK("adr", 10'h040, op_addr)
    wr(14'h0008, 8'h33);
    cyc(2);
    `CHK("opnv", 1'b1, op_nv)
    `CHK("dat", 8'h33, op_data)
    `CHK("mir", 1'b0, mirror_en)
    wr(14'h0000, 8'h00);
    $display("test redundant done");
    end_of_test;
end
endmodule // eeprom_ctl_tb
